// ===== logic/dtb_debug_unit.sv
// Debug event logic: breakpoints, trace and debug state registers
`timescale 1ns/1ps
//
// Behaviour
// RULE1: Control applies only when data breaks enabled
// RULE2: Control bits 6-7 report data match status
// RULE3: Breakpoint registers accessible only in supervisor
// RULE4: Single step traps after next completion
// RULE5: Branch trace traps after each branch
// RULE6: Fault address loaded with matching data address
// RULE7: Cause bit 9 set on data break
// RULE8: Data break raises storage interrupt 00300
// RULE9: Instruction break raises interrupt 01300
// RULE10: Trace interrupt taken at vector 00D00
// RULE11: Other vectors untouched by breakpoints
// RULE12: No step trace for sync-type instructions
// RULE13: Step set by return: one instruction
// RULE14: Interrupt saves state word, clears step
// RULE15: Step skips branches; branch trace covers
// RULE16: Software changes step via saved state
// RULE17: Data break taken before access executes
// RULE18: Instruction break beats data break
// RULE19: Single trace when both modes fire
module dtb_debug_unit
  import dtb_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire dtb_pkg::dtb_instr_t   instr,
  input  wire dtb_pkg::dtb_spr_req_t spr_req,
  input  wire logic                  msw_wr,
  input  wire logic [31:0]           msw_wdata,
  input  wire logic                  rfi,
  input  wire logic                  other_exc,
  output logic                       exc_take_r,
  output logic [19:0]                exc_vector_r,
  output logic [31:0]                exc_pc_r,
  output logic                       commit_block_r,
  output logic [31:0]                spr_rdata_r,
  output logic                       spr_priv_err_r,
  output logic [31:0]                machine_state_word_r,
  output logic [31:0]                saved_return_state_r
);
  import dtb_pkg::*;

  // Breakpoint and fault registers
  logic [31:0] data_break_control_r;        // Data control and match status
  logic [31:0] data_break_address_r;        // First data break address
  logic [31:0] second_data_break_address_r; // Second data break address
  logic [31:0] instr_break_address_r;       // First instruction break address
  logic [31:0] second_instr_break_address_r;// Second instruction break address
  logic [31:0] instr_break_control_r;       // Instruction control and status
  logic [31:0] data_fault_address_r;        // Faulting data address
  logic [31:0] data_fault_cause_r;          // Fault cause
  logic        supervisor;                  // Privilege check
  logic        spr_ok;                      // Access permitted
  logic        dhit1, dhit2;                // Data comparator hits
  logic        ihit1, ihit2;                // Instruction comparator hits
  logic        dbrk, ibrk, trace_hit;       // Event decisions
  logic        rd_en1, rd_en2, wr_en1, wr_en2;
  logic        step_en, branch_en;
  dtb_exc_t    exc_kind;                    // Chosen exception

  assign supervisor = !machine_state_word_r[USER_MODE_BIT];
  assign spr_ok     = supervisor;                              // see RULE3
  assign step_en    = machine_state_word_r[SINGLE_STEP_BIT];
  assign branch_en  = machine_state_word_r[BRANCH_TRACE_BIT];

  // Per-direction enables of each data break register
  assign rd_en1 = data_break_address_r[READ_EN_BIT] && instr.mem_rd;
  assign wr_en1 = data_break_address_r[WRITE_EN_BIT] && instr.mem_wr;
  assign rd_en2 = second_data_break_address_r[READ_EN_BIT] && instr.mem_rd;
  assign wr_en2 = second_data_break_address_r[WRITE_EN_BIT] && instr.mem_wr;

  // Data address comparators; control only counts through these enables
  dtb_addr_cmp u_dcmp1 (
    .brk_reg (data_break_address_r),
    .addr    (instr.ea),
    .en      (rd_en1 || wr_en1),                               // see RULE1
    .hit     (dhit1)
  );
  dtb_addr_cmp u_dcmp2 (
    .brk_reg (second_data_break_address_r),
    .addr    (instr.ea),
    .en      (rd_en2 || wr_en2),                               // see RULE1
    .hit     (dhit2)
  );

  // Instruction address comparators
  dtb_addr_cmp u_icmp1 (
    .brk_reg (instr_break_address_r),
    .addr    (instr.pc),
    .en      (instr_break_address_r[IBRK_EN_BIT]),
    .hit     (ihit1)
  );
  dtb_addr_cmp u_icmp2 (
    .brk_reg (second_instr_break_address_r),
    .addr    (instr.pc),
    .en      (second_instr_break_address_r[IBRK_EN_BIT]),
    .hit     (ihit2)
  );

  // Trace decision block
  dtb_trace_ctl u_trace (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .completing (instr.valid),
    .is_branch  (instr.is_branch),
    .no_step    (instr.no_step),
    .step_en    (step_en),
    .branch_en  (branch_en),
    .trace_hit  (trace_hit)
  );

  assign ibrk = instr.valid && (ihit1 || ihit2);                // see RULE9
  assign dbrk = instr.valid && (dhit1 || dhit2);                // see RULE8

  // Priority: instruction break, then data break, then trace
  always_comb begin
    if (ibrk) begin
      exc_kind = DTB_EXC_IBRK;                                  // see RULE18
    end else if (dbrk) begin
      exc_kind = DTB_EXC_DSI;
    end else if (trace_hit) begin
      exc_kind = DTB_EXC_TRACE;                                 // see RULE10
    end else begin
      exc_kind = DTB_EXC_NONE;
    end
  end

  // Exception request toward the core; other causes keep their own vectors
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      exc_take_r     <= 1'b0;
      exc_vector_r   <= 20'h00000;
      exc_pc_r       <= RESET_WORD;
      commit_block_r <= 1'b0;
    end else begin
      exc_take_r     <= (exc_kind != DTB_EXC_NONE) && !other_exc;  // see RULE11
      // Breaks stop the tagged instruction from committing
      commit_block_r <= (exc_kind == DTB_EXC_IBRK) ||
                        (exc_kind == DTB_EXC_DSI);                 // see RULE17
      exc_pc_r       <= instr.pc;
      // A vector shows only with a taken request, never beside another cause
      if (other_exc) begin
        exc_vector_r <= 20'h00000;                                 // see RULE11
      end else begin
        case (exc_kind)
          DTB_EXC_IBRK:  exc_vector_r <= VEC_INSTR_BREAK;          // see RULE9
          DTB_EXC_DSI:   exc_vector_r <= VEC_DATA_STORAGE;         // see RULE8
          DTB_EXC_TRACE: exc_vector_r <= VEC_TRACE;                // see RULE10
          default:       exc_vector_r <= 20'h00000;
        endcase
      end
    end
  end

  // State word and saved copy; any interrupt saves state and stops stepping
  // An interrupt beats a return in the same cycle, so no stale step leaks out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      machine_state_word_r <= RESET_WORD;
      saved_return_state_r <= RESET_WORD;
    end else if ((exc_kind != DTB_EXC_NONE) || other_exc) begin
      saved_return_state_r <= machine_state_word_r;                // see RULE14
      machine_state_word_r[SINGLE_STEP_BIT] <= 1'b0;               // see RULE14
    end else if (rfi) begin
      // Restoring step here traps after the next completion
      machine_state_word_r <= saved_return_state_r;                // see RULE13
    end else if (msw_wr) begin
      machine_state_word_r <= msw_wdata;
    end else if (spr_req.wr && spr_ok && spr_req.sel == DTB_SEL_NONE) begin
      // Software edits the saved state to steer stepping
      saved_return_state_r <= spr_req.wdata;                       // see RULE16
    end
  end

  // Data fault capture; hardware set wins over software write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_fault_address_r <= RESET_WORD;
      data_fault_cause_r   <= RESET_WORD;
    end else if (exc_kind == DTB_EXC_DSI) begin
      data_fault_address_r <= instr.ea;                            // see RULE6
      data_fault_cause_r[CAUSE_BREAK_BIT] <= 1'b1;                 // see RULE7
    end else if (spr_req.wr && spr_ok) begin
      if (spr_req.sel == DTB_SEL_DFA) begin
        data_fault_address_r <= spr_req.wdata;
      end else if (spr_req.sel == DTB_SEL_DFC) begin
        data_fault_cause_r <= spr_req.wdata;
      end
    end
  end

  // Breakpoint registers; writes only in supervisor mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_break_address_r         <= RESET_WORD;
      second_data_break_address_r  <= RESET_WORD;
      instr_break_address_r        <= RESET_WORD;
      second_instr_break_address_r <= RESET_WORD;
    end else if (spr_req.wr && spr_ok) begin                       // see RULE3
      if (spr_req.sel == DTB_SEL_DBA) begin
        data_break_address_r <= spr_req.wdata;
      end else if (spr_req.sel == DTB_SEL_DBA2) begin
        second_data_break_address_r <= spr_req.wdata;
      end else if (spr_req.sel == DTB_SEL_IBA) begin
        instr_break_address_r <= spr_req.wdata;
      end else if (spr_req.sel == DTB_SEL_IBA2) begin
        second_instr_break_address_r <= spr_req.wdata;
      end
    end
  end

  // Control registers with match status; a match sets status over a write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_break_control_r  <= RESET_WORD;
      instr_break_control_r <= RESET_WORD;
    end else begin
      if (spr_req.wr && spr_ok && spr_req.sel == DTB_SEL_DBC) begin
        data_break_control_r <= spr_req.wdata;
      end
      if (spr_req.wr && spr_ok && spr_req.sel == DTB_SEL_IBC) begin
        instr_break_control_r <= spr_req.wdata;
      end
      if (instr.valid && dhit1) begin
        data_break_control_r[DBC_STAT_LO] <= 1'b1;                 // see RULE2
      end
      if (instr.valid && dhit2) begin
        data_break_control_r[DBC_STAT_HI] <= 1'b1;                 // see RULE2
      end
      if (instr.valid && ihit1) begin
        instr_break_control_r[DBC_STAT_LO] <= 1'b1;
      end
      if (instr.valid && ihit2) begin
        instr_break_control_r[DBC_STAT_HI] <= 1'b1;
      end
    end
  end

  // Register reads; user mode reads zero and flags a privilege error
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spr_rdata_r    <= RESET_WORD;
      spr_priv_err_r <= 1'b0;
    end else begin
      spr_priv_err_r <= (spr_req.rd || spr_req.wr) && !spr_ok;    // see RULE3
      if (spr_req.rd && spr_ok) begin
        if (spr_req.sel == DTB_SEL_DBC) begin
          spr_rdata_r <= data_break_control_r;
        end else if (spr_req.sel == DTB_SEL_DBA) begin
          spr_rdata_r <= data_break_address_r;
        end else if (spr_req.sel == DTB_SEL_DBA2) begin
          spr_rdata_r <= second_data_break_address_r;
        end else if (spr_req.sel == DTB_SEL_IBA) begin
          spr_rdata_r <= instr_break_address_r;
        end else if (spr_req.sel == DTB_SEL_IBA2) begin
          spr_rdata_r <= second_instr_break_address_r;
        end else if (spr_req.sel == DTB_SEL_IBC) begin
          spr_rdata_r <= instr_break_control_r;
        end else if (spr_req.sel == DTB_SEL_DFA) begin
          spr_rdata_r <= data_fault_address_r;
        end else if (spr_req.sel == DTB_SEL_DFC) begin
          spr_rdata_r <= data_fault_cause_r;
        end else begin
          spr_rdata_r <= saved_return_state_r;
        end
      end else begin
        spr_rdata_r <= RESET_WORD;
      end
    end
  end

  // Assertions
  property p_ibrk_vec;
    @(posedge clk) disable iff (sys_rst)
      (ibrk && !other_exc) |=> (exc_take_r && exc_vector_r == 20'h01300);
  endproperty
  a_ibrk_vec: assert property (p_ibrk_vec) else $error("ibrk vector"); // see RULE9
  property p_dsi_vec;
    @(posedge clk) disable iff (sys_rst)
      (dbrk && !ibrk && !other_exc) |=> (exc_vector_r == 20'h00300 && commit_block_r);
  endproperty
  a_dsi_vec: assert property (p_dsi_vec) else $error("dsi vector"); // see RULE8
  property p_prio;
    @(posedge clk) disable iff (sys_rst)
      (ibrk && dbrk && !other_exc) |=> exc_vector_r == 20'h01300;
  endproperty
  a_prio: assert property (p_prio) else $error("priority"); // see RULE18
  property p_dfa;
    @(posedge clk) disable iff (sys_rst)
      (dbrk && !ibrk) |=> (data_fault_address_r == $past(instr.ea) &&
                           data_fault_cause_r[9]);
  endproperty
  a_dfa: assert property (p_dfa) else $error("fault capture"); // see RULE6
  property p_status;
    @(posedge clk) disable iff (sys_rst)
      (instr.valid && dhit1) |=> data_break_control_r[6];
  endproperty
  a_status: assert property (p_status) else $error("status bit"); // see RULE2
  property p_save;
    @(posedge clk) disable iff (sys_rst)
      other_exc |=> (saved_return_state_r == $past(machine_state_word_r) &&
                     !machine_state_word_r[21]);
  endproperty
  a_save: assert property (p_save) else $error("state save"); // see RULE14
  property p_priv;
    @(posedge clk) disable iff (sys_rst)
      (spr_req.wr && machine_state_word_r[17]) |=> spr_priv_err_r;
  endproperty
  a_priv: assert property (p_priv) else $error("privilege"); // see RULE3
  property p_trace;
    @(posedge clk) disable iff (sys_rst)
      (trace_hit && !ibrk && !dbrk && !other_exc) |=> exc_vector_r == 20'h00d00;
  endproperty
  a_trace: assert property (p_trace) else $error("trace vector"); // see RULE10
  // Further checks on the registered answer one cycle after the event
  property p_other_quiet;
    @(posedge clk) disable iff (sys_rst)
      other_exc |=> (!exc_take_r && exc_vector_r == 20'h00000);
  endproperty
  a_other_quiet: assert property (p_other_quiet) else $error("other cause"); // see RULE11
  property p_rfi_restore;
    @(posedge clk) disable iff (sys_rst)
      (rfi && !other_exc && exc_kind == DTB_EXC_NONE) |=>
        (machine_state_word_r == $past(saved_return_state_r));
  endproperty
  a_rfi_restore: assert property (p_rfi_restore) else $error("return restore"); // see RULE13
  property p_exc_step_off;
    @(posedge clk) disable iff (sys_rst)
      (exc_kind != DTB_EXC_NONE) |=> !machine_state_word_r[SINGLE_STEP_BIT];
  endproperty
  a_exc_step_off: assert property (p_exc_step_off) else $error("step kept"); // see RULE14
  property p_user_nowrite;
    @(posedge clk) disable iff (sys_rst)
      (spr_req.wr && !spr_ok) |=> ($stable(instr_break_address_r) &&
                                   $stable(data_break_address_r));
  endproperty
  a_user_nowrite: assert property (p_user_nowrite) else $error("user write"); // see RULE3
  property p_status2;
    @(posedge clk) disable iff (sys_rst)
      (instr.valid && dhit2) |=> data_break_control_r[DBC_STAT_HI];
  endproperty
  a_status2: assert property (p_status2) else $error("status bit two"); // see RULE2
  c_ibrk:  cover property (@(posedge clk) ibrk);
  c_rfi:   cover property (@(posedge clk) rfi && saved_return_state_r[SINGLE_STEP_BIT]);
  c_dsi:   cover property (@(posedge clk) dbrk && !ibrk);
  c_trace: cover property (@(posedge clk) trace_hit && instr.is_branch && step_en);
endmodule // dtb_debug_unit

// ===== shared/dtb_pkg.sv
// Package for the debug trace and breakpoint unit: field positions, vectors, types
package dtb_pkg;

  // Machine state word bit positions (bit 0 is the least significant bit)
  localparam int unsigned USER_MODE_BIT   = 17;
  localparam int unsigned SINGLE_STEP_BIT = 21;
  localparam int unsigned BRANCH_TRACE_BIT = 22;

  // Data fault cause bit marking a breakpoint
  localparam int unsigned CAUSE_BREAK_BIT = 9;

  // Data break control status bits
  localparam int unsigned DBC_STAT_LO = 6;
  localparam int unsigned DBC_STAT_HI = 7;

  // Break address register enable fields
  localparam int unsigned READ_EN_BIT  = 0;
  localparam int unsigned WRITE_EN_BIT = 1;
  localparam int unsigned IBRK_EN_BIT  = 0;

  // Interrupt vector offsets
  localparam logic [19:0] VEC_DATA_STORAGE = 20'h00300;
  localparam logic [19:0] VEC_TRACE        = 20'h00d00;
  localparam logic [19:0] VEC_INSTR_BREAK  = 20'h01300;

  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Special register selectors seen on the register port
  typedef enum logic [3:0] {
    DTB_SEL_DBC   = 4'b0000,
    DTB_SEL_DBA   = 4'b0001,
    DTB_SEL_DBA2  = 4'b0010,
    DTB_SEL_IBA   = 4'b0011,
    DTB_SEL_IBA2  = 4'b0100,
    DTB_SEL_IBC   = 4'b0101,
    DTB_SEL_DFA   = 4'b0110,
    DTB_SEL_DFC   = 4'b0111,
    DTB_SEL_NONE  = 4'b1111
  } dtb_sel_t;

  // Exception kinds raised by the unit
  typedef enum logic [1:0] {
    DTB_EXC_NONE  = 2'b00,
    DTB_EXC_IBRK  = 2'b01,
    DTB_EXC_DSI   = 2'b10,
    DTB_EXC_TRACE = 2'b11
  } dtb_exc_t;

  // A completing instruction as seen by the completion logic
  typedef struct packed {
    logic        valid;     // Instruction completing this cycle
    logic [31:0] pc;        // Its effective address
    logic        is_branch; // Branch, return from interrupt or critical return
    logic        no_step;   // Sync, instruction sync, returns or state word move
    logic        mem_rd;    // Performs a data read
    logic        mem_wr;    // Performs a data write
    logic [31:0] ea;        // Data effective address
  } dtb_instr_t;

  // Special register access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    dtb_sel_t    sel;
    logic [31:0] wdata;
  } dtb_spr_req_t;

endpackage

// ===== logic/dtb_addr_cmp.sv
// Address comparator with enable for one breakpoint register
`timescale 1ns/1ps
module dtb_addr_cmp (
  input  wire logic [31:0] brk_reg,
  input  wire logic [31:0] addr,
  input  wire logic        en,
  output logic             hit
);
  // Low word-select bits hold enables, so compare the word address only
  assign hit = en && (brk_reg[31:2] == addr[31:2]);
endmodule // dtb_addr_cmp

// ===== logic/dtb_trace_ctl.sv
// Trace decision for single step and branch trace
`timescale 1ns/1ps
module dtb_trace_ctl (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic completing,
  input  wire logic is_branch,
  input  wire logic no_step,
  input  wire logic step_en,
  input  wire logic branch_en,
  output logic      trace_hit
);
  // One trace per instruction even when both modes fire (see RULE19)
  assign trace_hit = completing &&
                     ((step_en && !no_step && !is_branch) ||   // see RULE4 see RULE12 see RULE15
                      (branch_en && is_branch));               // see RULE5
  // Assertions
  property p_step_once;
    @(posedge clk) disable iff (sys_rst)
      (completing && step_en && !no_step && !is_branch) |-> trace_hit;
  endproperty
  a_step_once: assert property (p_step_once) else $error("step missed"); // see RULE4
  property p_sync_skip;
    @(posedge clk) disable iff (sys_rst)
      (completing && no_step && !is_branch) |-> !trace_hit;
  endproperty
  a_sync_skip: assert property (p_sync_skip) else $error("sync traced"); // see RULE12
endmodule // dtb_trace_ctl

// ===== tb/debug_trace_breakpoint_unit_tb.sv
// Self-checking bench for the debug trace and breakpoint unit
`timescale 1ns/1ps
module debug_trace_breakpoint_unit_tb;
  import dtb_pkg::*;

  logic                  clk;                  // Core clock, 25 ns
  logic                  sys_rst;              // Synchronous reset, active high
  dtb_pkg::dtb_instr_t   instr;                // Completing instruction
  dtb_pkg::dtb_spr_req_t spr_req;              // Register access request
  logic                  msw_wr;               // Move to state word
  logic [31:0]           msw_wdata;            // Its data
  logic                  rfi;                  // Return from interrupt
  logic                  other_exc;            // Non-debug exception
  logic                  exc_take_r;
  logic [19:0]           exc_vector_r;
  logic [31:0]           exc_pc_r;
  logic                  commit_block_r;
  logic [31:0]           spr_rdata_r;
  logic                  spr_priv_err_r;
  logic [31:0]           machine_state_word_r;
  logic [31:0]           saved_return_state_r;
  int                    n_mismatch;           // Mismatches seen
  int                    check_count;          // Comparisons made

  dtb_debug_unit dut (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .instr                (instr),
    .spr_req              (spr_req),
    .msw_wr               (msw_wr),
    .msw_wdata            (msw_wdata),
    .rfi                  (rfi),
    .other_exc            (other_exc),
    .exc_take_r           (exc_take_r),
    .exc_vector_r         (exc_vector_r),
    .exc_pc_r             (exc_pc_r),
    .commit_block_r       (commit_block_r),
    .spr_rdata_r          (spr_rdata_r),
    .spr_priv_err_r       (spr_priv_err_r),
    .machine_state_word_r (machine_state_word_r),
    .saved_return_state_r (saved_return_state_r)
  );

  // Free running core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Verdict in one place, used by the tests and the watchdog alike
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Word compare, four-state exact
  task automatic chk_word(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Exception compare: take flag and vector together
  task automatic chk_exc(logic take, logic [19:0] vec);
    check_count++;
    if ({exc_take_r, exc_vector_r} !== {take, vec}) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, {exc_take_r, exc_vector_r}, {take, vec});
    end
  endtask

  // Idle register request
  localparam dtb_spr_req_t SPR_IDLE = '{1'b0, 1'b0, DTB_SEL_NONE, 32'h0};

  // One cycle: every request assigned once, so pulses drop with the next call
  task automatic cyc(dtb_instr_t i, dtb_spr_req_t s, logic mw, logic rf, logic ox);
    instr     = i;
    spr_req   = s;
    msw_wr    = mw;
    rfi       = rf;
    other_exc = ox;
    @(posedge clk);
    #2;
  endtask

  // Idle cycle
  task automatic tick();
    cyc('0, SPR_IDLE, 1'b0, 1'b0, 1'b0);
  endtask

  // Return from interrupt for one cycle
  task automatic ret();
    cyc('0, SPR_IDLE, 1'b0, 1'b1, 1'b0);
  endtask

  // Register write through the special register port
  task automatic spr_wr(dtb_sel_t sel, logic [31:0] d);
    dtb_spr_req_t r;
    r = '{1'b0, 1'b1, sel, d};
    cyc('0, r, 1'b0, 1'b0, 1'b0);
  endtask

  // Register read; mask lets status fields be judged on their own
  task automatic spr_rd(dtb_sel_t sel, logic [31:0] mask, logic [31:0] exp);
    dtb_spr_req_t r;
    r = '{1'b1, 1'b0, sel, 32'h0};
    cyc('0, r, 1'b0, 1'b0, 1'b0);
    chk_word(spr_rdata_r & mask, exp);
  endtask

  // State word move, checked once it has landed
  task automatic msw_set(logic [31:0] v);
    msw_wdata = v;
    cyc('0, SPR_IDLE, 1'b1, 1'b0, 1'b0);
    chk_word(machine_state_word_r, v);
  endtask

  // Completing instruction, optionally beside a non-debug exception
  task automatic go_x(logic [31:0] pc, logic br, logic ns, logic rd, logic wr,
                      logic [31:0] ea, logic ox);
    dtb_instr_t i;
    i = '{1'b1, pc, br, ns, rd, wr, ea};
    cyc(i, SPR_IDLE, 1'b0, 1'b0, ox);
  endtask

  // One completing instruction; the answer is looked at in the following cycle
  task automatic go(logic [31:0] pc, logic br, logic ns, logic rd, logic wr, logic [31:0] ea);
    go_x(pc, br, ns, rd, wr, ea, 1'b0);
  endtask

  // Watchdog: the sequence needs about 53 cycles
  initial begin
    #(25 * 3000);
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    n_mismatch  = 0;
    check_count = 0;
    sys_rst     = 1'b1;
    instr       = '0;
    spr_req     = '{1'b0, 1'b0, DTB_SEL_NONE, 32'h0};
    msw_wr      = 1'b0;
    msw_wdata   = 32'h0;
    rfi         = 1'b0;
    other_exc   = 1'b0;
    repeat (10) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    chk_exc(1'b0, 20'h0);
    chk_word(machine_state_word_r, 32'h0);
    // Data breaks: disabled register and wrong direction must stay silent
    spr_wr(DTB_SEL_DBA, 32'h0000_1001);
    spr_wr(DTB_SEL_DBA2, 32'h0000_2000);
    go(32'h0000_0400, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_2000);
    chk_exc(1'b0, 20'h0);
    go(32'h0000_0400, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_1000);
    chk_exc(1'b0, 20'h0);
    go(32'h0000_0400, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_1000);
    chk_exc(1'b1, 20'h00300);
    chk_word(exc_pc_r, 32'h0000_0400);
    chk_word({31'h0, commit_block_r}, 32'h1);
    spr_rd(DTB_SEL_DFA, 32'hffff_ffff, 32'h0000_1000);
    spr_rd(DTB_SEL_DFC, 32'h0000_0200, 32'h0000_0200);
    spr_rd(DTB_SEL_DBC, 32'h0000_00c0, 32'h0000_0040);
    spr_rd(DTB_SEL_DBA, 32'hffff_ffff, 32'h0000_1001);
    // Second register, write direction, status in the upper bit
    spr_wr(DTB_SEL_DBC, 32'h0);
    spr_wr(DTB_SEL_DBA2, 32'h0000_2002);
    go(32'h0000_0440, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_2000);
    chk_exc(1'b1, 20'h00300);
    spr_rd(DTB_SEL_DFA, 32'hffff_ffff, 32'h0000_2000);
    spr_rd(DTB_SEL_DBC, 32'h0000_0080, 32'h0000_0080);
    // Instruction break alone, then together with a data break
    spr_wr(DTB_SEL_IBA, 32'h0000_0801);
    go(32'h0000_0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b1, 20'h01300);
    chk_word(exc_pc_r, 32'h0000_0800);
    go(32'h0000_0800, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_1000);
    chk_exc(1'b1, 20'h01300);
    // A non-debug exception keeps its own path untouched
    go_x(32'h0000_0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1);
    chk_exc(1'b0, 20'h0);
    spr_wr(DTB_SEL_IBA, 32'h0);
    // Single step: sync-type and branch skipped, plain instruction traps
    msw_set(32'h0020_0000);
    go(32'h0000_0900, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b0, 20'h0);
    go(32'h0000_0904, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b0, 20'h0);
    go(32'h0000_0908, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b1, 20'h00d00);
    chk_word({31'h0, commit_block_r}, 32'h0);
    chk_word(machine_state_word_r, 32'h0);
    chk_word(saved_return_state_r, 32'h0020_0000);
    // Step restored by return: exactly one instruction, then trap, then quiet
    ret();
    chk_word(machine_state_word_r, 32'h0020_0000);
    go(32'h0000_090c, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b1, 20'h00d00);
    go(32'h0000_0910, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b0, 20'h0);
    // Branch trace alone, then with step: one trap per branch
    msw_set(32'h0040_0000);
    go(32'h0000_0a00, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b0, 20'h0);
    go(32'h0000_0a04, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b1, 20'h00d00);
    msw_set(32'h0060_0000);
    go(32'h0000_0a08, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b1, 20'h00d00);
    tick();
    chk_exc(1'b0, 20'h0);
    // With both modes clear, execution is plain
    msw_set(32'h0);
    go(32'h0000_0a0c, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b0, 20'h0);
    // User mode: access refused and without effect
    msw_set(32'h0002_0000);
    spr_wr(DTB_SEL_IBA, 32'h0000_0801);
    chk_word({31'h0, spr_priv_err_r}, 32'h1);
    spr_rd(DTB_SEL_IBA, 32'hffff_ffff, 32'h0);
    chk_word({31'h0, spr_priv_err_r}, 32'h1);
    go(32'h0000_0800, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b0, 20'h0);
    msw_set(32'h0);
    spr_rd(DTB_SEL_DBA2, 32'hffff_ffff, 32'h0000_2002);
    chk_word({31'h0, spr_priv_err_r}, 32'h0);
    // Stepping steered through the saved state and a return
    spr_wr(DTB_SEL_NONE, 32'h0020_0000);
    chk_word(saved_return_state_r, 32'h0020_0000);
    ret();
    chk_word(machine_state_word_r, 32'h0020_0000);
    go(32'h0000_0b00, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
    chk_exc(1'b1, 20'h00d00);
    give_verdict();
  end
endmodule // debug_trace_breakpoint_unit_tb
